/* File: hw/serial_rate_pkg.sv */
// Purpose: shared constants and types for the second serial controller (rate generator and SPI)
// Assumes: register indices are scaled by four to byte addresses on the register bus
// Notes: all configuration fields sit in the low byte of each 16-bit register
package serial_rate_pkg;
   // register indices and byte addresses
   localparam int ADDR_W = 17;
   localparam logic [14:0] IDX_DATA = 15'h441e;
   localparam logic [14:0] IDX_STATUS = 15'h4420;
   localparam logic [14:0] IDX_MODE = 15'h442a;
   localparam logic [14:0] IDX_SPI_CFG = 15'h442c;
   localparam logic [14:0] IDX_RATE_LIN = 15'h4430;
   localparam logic [14:0] IDX_RATE_EXP = 15'h4432;
   localparam logic [ADDR_W-1:0] ADDR_DATA = {IDX_DATA, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MODE = {IDX_MODE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_SPI_CFG = {IDX_SPI_CFG, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_RATE_LIN = {IDX_RATE_LIN, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_RATE_EXP = {IDX_RATE_EXP, 2'b00};
   // spi_configuration fields
   localparam int CFG_W = 6;
   localparam int CFG_POL = 0;
   localparam int CFG_PHA = 1;
   localparam int CFG_ORD = 2;
   localparam int CFG_RPT = 3;
   localparam int CFG_MST = 4;
   localparam int CFG_RXDRV = 5;
   localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
   // status fields
   localparam int ST_RXOVF = 0;
   localparam int ST_RXVAL = 1;
   localparam int ST_TXFREE = 2;
   localparam int ST_TXIDLE = 3;
   // controller_mode_select decode
   localparam logic [1:0] MODE_SPI = 2'h2;
   localparam logic [1:0] MODE_I2C = 2'h3;
   localparam logic [1:0] MODE_RESET = 2'h0;
   // rate terms
   localparam int TERM_W = 4;
   localparam int EXP_CNT_W = 16;
   localparam logic [TERM_W-1:0] TERM_RESET = 4'h0;
   localparam int REF_HZ = 24_000_000;
   // data
   localparam logic [7:0] BUSY_TOKEN = 8'hff;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [4:0] LAST_EDGE = 5'h0f;

   typedef enum logic [1:0] {
      XFER_IDLE = 2'b00,
      XFER_BUSY = 2'b01
   } xfer_state_t;
endpackage

/* File: hw/rate_if.sv */
`timescale 1ns/1ps
// Purpose: carries the rate terms, run request and half-period tick between controller and generator
// Assumes: one clock domain
// Notes: none
interface rate_if;
   logic [3:0] linear;
   logic [3:0] exponent;
   logic run;
   logic tick;
   modport gen (input linear, input exponent, input run, output tick);
   modport user (output linear, output exponent, output run, input tick);
endinterface

/* File: hw/rate_generator.sv */
`timescale 1ns/1ps
// Purpose: half-period tick generator: linear prescaler followed by an exponent stage
// Assumes: clk is the reference clock of the serial rate
// Notes: tick is one cycle wide, every (linear+1)*2^exponent cycles while run is high
module rate_generator
   import serial_rate_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // rate terms and tick
   rate_if.gen rate
);
   typedef struct packed {
      logic [TERM_W-1:0] lin_cnt;
      logic [EXP_CNT_W-1:0] exp_cnt;
      logic tick;
   } gen_state_t;

   gen_state_t q;
   gen_state_t next_q;
   logic [EXP_CNT_W-1:0] exp_last;

   always_comb begin
      next_q = q;
      exp_last = EXP_CNT_W'((EXP_CNT_W'(1) << rate.exponent) - EXP_CNT_W'(1));
      next_q.tick = 1'b0;
      if (!rate.run) begin
         // restart each frame so the first half period is whole
         next_q.lin_cnt = '0;
         next_q.exp_cnt = '0;
      end else if (q.lin_cnt == rate.linear) begin
         next_q.lin_cnt = '0;
         if (q.exp_cnt == exp_last) begin
            next_q.exp_cnt = '0;
            next_q.tick = 1'b1;
         end else begin
            next_q.exp_cnt = EXP_CNT_W'(q.exp_cnt + EXP_CNT_W'(1));
         end
      end else begin
         next_q.lin_cnt = TERM_W'(q.lin_cnt + TERM_W'(1));
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign rate.tick = q.tick;
endmodule

/* File: hw/serial_spi_controller.sv */
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
// Purpose: register file, rate terms and one-byte SPI engine of the second serial controller
// Assumes: Avalon-MM slave with waitrequest, byte addresses; SPI pins sampled through two flip-flops
// Notes: transmit and receive holding registers are one byte deep; no interrupt logic here
module serial_spi_controller
   import serial_rate_pkg::*;
#(
   parameter int DATA_W = 32
)(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [DATA_W-1:0] writedata,
   input wire logic [DATA_W/8-1:0] byteenable,
   output logic [DATA_W-1:0] readdata,
   output logic waitrequest,
   // spi clock pin
   input wire logic spi_clk_in,
   output logic spi_clk_out,
   output logic spi_clk_oe,
   // spi select pin, active low
   input wire logic spi_select_n_in,
   output logic spi_select_n_out,
   output logic spi_select_n_oe,
   // master-out data pin
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   // master-in data pin
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe
);
   if (DATA_W < 16 || DATA_W % 8 != 0) begin : g_bad_width
      $error("DATA_W must be a whole number of bytes and at least 16");
   end

   typedef struct packed {
      logic wait_req;
      logic [15:0] rdata;
      logic [1:0] mode;
      logic [CFG_W-1:0] cfg;
      logic [TERM_W-1:0] lin;
      logic [TERM_W-1:0] expo;
      logic [7:0] tx_hold;
      logic tx_full;
      logic [7:0] rx_hold;
      logic rx_val;
      logic rx_ovf;
      logic rpt_act;
      logic [7:0] last_tx;
      xfer_state_t st;
      logic [7:0] tx_sh;
      logic [7:0] rx_sh;
      logic [2:0] cnt;
      logic [4:0] edges;
      logic skip;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [1:0] prev;
      logic sclk_o;
      logic sel_n_o;
      logic mosi_o;
      logic miso_o;
      logic master_oe;
      logic slave_oe;
   } ctl_state_t;

   ctl_state_t q;
   ctl_state_t next_q;
   rate_if rate ();

   rate_generator u_rate (
      .clk(clk),
      .reset_n(reset_n),
      .rate(rate)
   );

   assign rate.linear = q.lin;
   assign rate.exponent = q.expo;
   assign rate.run = q.st == XFER_BUSY && q.cfg[CFG_MST];

   function automatic logic [7:0] shift_tx(input logic [7:0] v, input logic lsb);
      return lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] insert_rx(input logic [7:0] v, input logic b, input logic lsb);
      return lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   always_comb begin
      logic req;
      logic done;
      logic pop;
      logic spi_on;
      logic master;
      logic lsb;
      logic cpha;
      logic lead;
      logic trail;
      logic sample_ev;
      logic adv_ev;
      logic in_bit;
      logic selected;
      logic tx_idle;
      logic load;
      logic [7:0] rx_byte;
      logic [7:0] load_byte;
      next_q = q;
      lead = 1'b0;
      trail = 1'b0;
      in_bit = q.sync2[1];
      req = read || write;
      done = req && !q.wait_req;
      pop = done && read && address == ADDR_DATA;
      spi_on = q.mode == MODE_SPI;
      master = q.cfg[CFG_MST];
      lsb = q.cfg[CFG_ORD];
      cpha = q.cfg[CFG_PHA];
      selected = !q.sync2[2];
      tx_idle = !q.tx_full && q.st == XFER_IDLE;
      load = 1'b0;
      rx_byte = '0;
      load_byte = BUSY_TOKEN;

      // bus answer: one cycle of waitrequest, then the access completes
      next_q.wait_req = !(req && q.wait_req);
      if (req && q.wait_req && read) begin
         case (address)
            ADDR_DATA: next_q.rdata = {8'h00, q.rx_hold};
            ADDR_STATUS: next_q.rdata = {12'h000, tx_idle, !q.tx_full, q.rx_val, q.rx_ovf};
            ADDR_MODE: next_q.rdata = {14'h0000, q.mode};
            ADDR_SPI_CFG: next_q.rdata = {10'h000, q.cfg};
            ADDR_RATE_LIN: next_q.rdata = {12'h000, q.lin};
            ADDR_RATE_EXP: next_q.rdata = {12'h000, q.expo};
            default: next_q.rdata = '0;
         endcase
      end
      if (pop) begin
         next_q.rx_val = 1'b0;
         next_q.rx_ovf = 1'b0;
      end
      // pin synchronisers: order is clock, select, mosi, miso
      next_q.sync1 = {spi_clk_in, spi_select_n_in, mosi_in, miso_in};
      next_q.sync2 = q.sync1;
      next_q.prev = q.sync2[3:2];
      // leading and trailing edges, from the rate ticks or the sampled pin
      if (master) begin
         lead = rate.tick && !q.edges[0];
         trail = rate.tick && q.edges[0];
         in_bit = q.sync2[0];
      end else begin
         lead = q.sync2[3] != q.prev[1] && q.sync2[3] != q.cfg[CFG_POL];
         trail = q.sync2[3] != q.prev[1] && q.sync2[3] == q.cfg[CFG_POL];
      end
      sample_ev = cpha ? trail : lead;
      adv_ev = cpha ? lead : trail;

      if (!spi_on) begin
         next_q.st = XFER_IDLE;
         next_q.sel_n_o = 1'b1;
         next_q.sclk_o = q.cfg[CFG_POL];
      end else if (q.st == XFER_IDLE) begin
         if (master) begin
            // rx-driven mode keeps clocking as long as the receive side has room
            load = q.cfg[CFG_RXDRV] ? !q.rx_val : q.tx_full;
         end else begin
            load = selected;
         end
         if (load) begin
            next_q.st = XFER_BUSY;
            next_q.sel_n_o = !master;
            next_q.edges = '0;
            next_q.cnt = '0;
            next_q.skip = cpha;
         end
      end else begin
         if (adv_ev) begin
            if (q.skip) begin
               next_q.skip = 1'b0;
            end else begin
               next_q.tx_sh = shift_tx(q.tx_sh, lsb);
            end
         end
         if (sample_ev) begin
            rx_byte = insert_rx(q.rx_sh, in_bit, lsb);
            next_q.rx_sh = rx_byte;
            next_q.cnt = 3'(q.cnt + 3'h1);
            if (q.cnt == LAST_BIT) begin
               next_q.rx_hold = rx_byte;
               next_q.rx_val = 1'b1;
               // a read in the same cycle takes the old byte, so the new byte raises no overrun
               if (q.rx_val && !pop) begin
                  next_q.rx_ovf = 1'b1;
               end
               if (!master) begin
                  load = 1'b1;
                  next_q.skip = 1'b1;
               end
            end
         end
         if (master && rate.tick) begin
            next_q.edges = 5'(q.edges + 5'h01);
            next_q.sclk_o = !q.sclk_o;
            if (q.edges == LAST_EDGE) begin
               next_q.st = XFER_IDLE;
               next_q.sel_n_o = 1'b1;
            end
         end
         if (!master && !selected) begin
            next_q.st = XFER_IDLE;
            load = 1'b0;
         end
      end

      if (load) begin
         if (q.tx_full) begin
            load_byte = q.tx_hold;
            next_q.tx_full = 1'b0;
         end else if (!master && q.rpt_act) begin
            load_byte = q.last_tx;
         end else begin
            load_byte = BUSY_TOKEN;
         end
         next_q.tx_sh = load_byte;
         next_q.last_tx = load_byte;
      end

      // the repeat choice must not change under a byte already committed
      if (tx_idle) begin
         next_q.rpt_act = q.cfg[CFG_RPT];
      end

      // register writes; a push after a load in the same cycle still lands
      if (done && write && byteenable[0]) begin
         case (address)
            ADDR_DATA: begin
               next_q.tx_hold = writedata[7:0];
               next_q.tx_full = 1'b1;
            end
            ADDR_MODE: next_q.mode = writedata[1:0];
            ADDR_SPI_CFG: next_q.cfg = writedata[CFG_W-1:0];
            ADDR_RATE_LIN: next_q.lin = writedata[TERM_W-1:0];
            ADDR_RATE_EXP: next_q.expo = writedata[TERM_W-1:0];
            default: next_q.mode = q.mode;
         endcase
      end

      next_q.master_oe = spi_on && master;
      next_q.slave_oe = spi_on && !master && selected && next_q.st == XFER_BUSY;
      next_q.mosi_o = lsb ? next_q.tx_sh[0] : next_q.tx_sh[7];
      next_q.miso_o = lsb ? next_q.tx_sh[0] : next_q.tx_sh[7];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.wait_req <= 1'b1;
         q.mode <= MODE_RESET;
         q.cfg <= CFG_RESET;
         q.lin <= TERM_RESET;
         q.expo <= TERM_RESET;
         q.sync1 <= 4'hf;
         q.sync2 <= 4'hf;
         q.prev <= 2'h3;
         q.sel_n_o <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign readdata = {{(DATA_W-16){1'b0}}, q.rdata};
   assign waitrequest = q.wait_req;
   assign spi_clk_out = q.sclk_o;
   assign spi_clk_oe = q.master_oe;
   assign spi_select_n_out = q.sel_n_o;
   assign spi_select_n_oe = q.master_oe;
   assign mosi_out = q.mosi_o;
   assign mosi_oe = q.master_oe;
   assign miso_out = q.miso_o;
   assign miso_oe = q.slave_oe;
endmodule

/* File: tb/serial_spi_controller_assertions.sv */
`timescale 1ns/1ps
// Purpose: port checks of the serial controller
// Assumes: writes land at the edge where waitrequest is low
// Notes: register contents are tracked by watching the bus
module spi_ctl_check
   import serial_rate_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register bus
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // spi pins
   input wire logic spi_clk_out,
   input wire logic spi_clk_oe,
   input wire logic spi_select_n_out,
   input wire logic spi_select_n_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe
);
   logic [3:0] lin, ex;
   logic [5:0] cfg;
   logic [1:0] mode;
   logic [19:0] cnt;
   logic run;
   wire rd = read && !waitrequest;
   wire wr = write && !waitrequest && byteenable[0];
   wire men = mode == MODE_SPI && cfg[CFG_MST];
   wire sen = mode == MODE_SPI && !cfg[CFG_MST];
   wire [19:0] half = 20'(lin + 5'h1) << ex;
   // run skips the first toggle, whose lead-in from select is not one half period
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {lin, ex, cfg, mode, cnt, run} <= '0;
      end else begin
         if (wr && address == ADDR_RATE_LIN) lin <= writedata[3:0];
         if (wr && address == ADDR_RATE_EXP) ex <= writedata[3:0];
         if (wr && address == ADDR_SPI_CFG) cfg <= writedata[5:0];
         if (wr && address == ADDR_MODE) mode <= writedata[1:0];
         cnt <= $changed(spi_clk_out) ? 20'h0 : cnt + 20'h1;
         run <= !spi_select_n_out && (run || $changed(spi_clk_out));
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_lin; rd && address == ADDR_RATE_LIN |-> readdata == {28'h0, lin}; endproperty
   a_lin: assert property (p_lin) else $error("linear term readback wrong");
   property p_ex; rd && address == ADDR_RATE_EXP |-> readdata == {28'h0, ex}; endproperty
   a_ex: assert property (p_ex) else $error("exponent term readback wrong");
   property p_cfg; rd && address == ADDR_SPI_CFG |-> readdata == {26'h0, cfg}; endproperty
   a_cfg: assert property (p_cfg) else $error("configuration readback wrong");
   property p_half; run && $changed(spi_clk_out) |-> cnt == half - 20'h1; endproperty
   a_half: assert property (p_half) else $error("serial half period wrong");
   property p_moe; men == $past(men) |-> spi_clk_oe == men; endproperty
   a_moe: assert property (p_moe) else $error("master drive enable wrong");
   property p_soe; miso_oe |-> sen || $past(sen); endproperty
   a_soe: assert property (p_soe) else $error("slave data driven outside slave mode");
   property p_grp; mosi_oe == spi_clk_oe && spi_select_n_oe == spi_clk_oe; endproperty
   a_grp: assert property (p_grp) else $error("master pins enabled apart");
   property p_sel; !spi_select_n_out |-> spi_clk_oe; endproperty
   a_sel: assert property (p_sel) else $error("select asserted while not master");
   property p_idle; spi_select_n_out && $past(spi_select_n_out) && men && $past(men) |-> $stable(spi_clk_out);
   endproperty
   a_idle: assert property (p_idle) else $error("serial clock moves between frames");
   c_xfer: cover property ($rose(spi_select_n_out) && spi_clk_oe);
   c_slave: cover property (miso_oe);
   c_cfg: cover property (rd && address == ADDR_SPI_CFG);
endmodule
bind serial_spi_controller spi_ctl_check chk (.clk, .reset_n, .address, .read, .write, .writedata, .byteenable,
   .readdata, .waitrequest, .spi_clk_out, .spi_clk_oe, .spi_select_n_out, .spi_select_n_oe, .mosi_oe, .miso_oe);

/* File: tb/spi_far_end.sv */
`timescale 1ns/1ps
// Purpose: external spi device, slave to a master controller or master to a slave one
// Assumes: clock polarity 0, phase 0, msb first on its own side
// Notes: released data line shows the inverse of its last value
module spi_far_end
   import serial_rate_pkg::*;
#(
   parameter logic [7:0] RESP = 8'hc5
)(
   // clock
   input wire logic clk,
   // resolved pins
   input wire logic sck,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic miso,
   // drives toward the controller
   output logic p_sck,
   output logic p_sel_n,
   output logic p_mosi,
   output logic p_miso
);
   logic [7:0] got;
   int k;
   initial {p_sck, p_sel_n, p_mosi, p_miso} = 4'h4;
   always @(negedge sel_n) begin
      k = 7;
      got = 8'h00;
      p_miso = RESP[7];
   end
   always @(posedge sck) if (!sel_n) got = {got[6:0], mosi};
   always @(negedge sck) if (!sel_n && k > 0) begin
      k = k - 1;
      p_miso = RESP[k];
   end
   always @(posedge sel_n) p_miso = ~p_miso;
   // link clock period is eight controller clocks
   task automatic sl_byte(input logic [7:0] b, output logic [7:0] seen);
      seen = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         p_mosi <= b[i];
         repeat (4) @(posedge clk);
         p_sck <= 1'b1;
         seen = {seen[6:0], miso};
         repeat (4) @(posedge clk);
         p_sck <= 1'b0;
      end
   endtask
endmodule

/* File: tb/test_serial_rate_and_spi_config.sv */
`timescale 1ns/1ps
// Purpose: self-checking bench of the serial controller
// Assumes: far end at clock polarity 0, phase 0
// Notes: master runs use a half period of four clocks
module test_serial_rate_and_spi_config
   import serial_rate_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] readdata;
   logic waitrequest, spi_clk_out, spi_clk_oe, spi_select_n_out, spi_select_n_oe;
   logic mosi_out, mosi_oe, miso_out, miso_oe, p_sck, p_sel_n, p_mosi, p_miso;
   int bad_count = 0;
   int n_tests = 0;
   wire sck = spi_clk_oe ? spi_clk_out : p_sck;
   wire sel_n = spi_select_n_oe ? spi_select_n_out : p_sel_n;
   wire mosi = mosi_oe ? mosi_out : p_mosi;
   wire miso = miso_oe ? miso_out : p_miso;
   always #20 clk = ~clk;
   serial_spi_controller DUT (.clk, .reset_n, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .spi_clk_in(sck), .spi_clk_out, .spi_clk_oe, .spi_select_n_in(sel_n), .spi_select_n_out,
      .spi_select_n_oe, .mosi_in(mosi), .mosi_out, .mosi_oe, .miso_in(miso), .miso_out, .miso_oe);
   spi_far_end P (.clk, .sck, .sel_n, .mosi, .miso, .p_sck, .p_sel_n, .p_mosi, .p_miso);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   function automatic logic [7:0] rev(input logic [7:0] b);
      for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
   endfunction
   task automatic t_regs();
      logic [ADDR_W-1:0] a[3] = '{ADDR_RATE_LIN, ADDR_RATE_EXP, ADDR_SPI_CFG};
      logic [31:0] m[3] = '{32'hf, 32'hf, 32'h3f};
      logic [31:0] q;
      for (int i = 0; i < 3; i++) begin
         rd(a[i], q);
         check("reset value", q, 32'h0);
         wr(a[i], 32'hffff_ffff);
         rd(a[i], q);
         check("readback", q, m[i]);
         wr(a[i], 32'h0);
      end
      rd(17'h00004, q);
      check("unmapped", q, 32'h0);
   endtask
   // modes 1 and 3 must leave the spi pins alone even with data waiting
   task automatic t_off();
      wr(ADDR_SPI_CFG, 32'h10);
      wr(ADDR_DATA, 32'h5a);
      for (int m = 1; m < 4; m += 2) begin
         wr(ADDR_MODE, 32'(m));
         repeat (40) @(posedge clk);
         check("pins off", {spi_clk_oe, sel_n}, 2'b01);
         wr(ADDR_MODE, 32'h0);
      end
   endtask
   task automatic t_master(input logic ord, input logic drv, input logic [7:0] tx);
      logic [31:0] q;
      logic [7:0] want;
      want = drv ? BUSY_TOKEN : tx;
      wr(ADDR_RATE_LIN, 32'h1);
      wr(ADDR_RATE_EXP, 32'h1);
      wr(ADDR_SPI_CFG, {26'h0, drv, 1'b1, 1'b0, ord, 2'b00});
      if (!drv) wr(ADDR_DATA, {24'h0, tx});
      wr(ADDR_MODE, 32'h2);
      wait (spi_select_n_out === 1'b0);
      wait (spi_select_n_out === 1'b1);
      repeat (4) @(posedge clk);
      check("mosi byte", P.got, ord ? rev(want) : want);
      wr(ADDR_MODE, 32'h0);
      rd(ADDR_DATA, q);
      check("miso byte", q, ord ? rev(P.RESP) : P.RESP);
   endtask
   task automatic t_slave(input logic rpt);
      logic [7:0] s;
      logic [31:0] q;
      wr(ADDR_SPI_CFG, {28'h0, rpt, 3'b000});
      wr(ADDR_DATA, 32'h3c);
      wr(ADDR_MODE, 32'h2);
      P.p_sel_n <= 1'b0;
      repeat (8) @(posedge clk);
      P.sl_byte(8'h5a, s);
      check("slave tx", s, 8'h3c);
      rd(ADDR_DATA, q);
      check("slave rx", q, 32'h5a);
      P.sl_byte(8'h81, s);
      check("underrun", s, rpt ? 8'h3c : BUSY_TOKEN);
      P.p_sel_n <= 1'b1;
      repeat (8) @(posedge clk);
      wr(ADDR_MODE, 32'h0);
      rd(ADDR_DATA, q);
      check("slave rx", q, 32'h81);
   endtask
   task automatic report_and_stop();
      if (bad_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_off();
      t_master(1'b0, 1'b0, 8'h3a);
      t_master(1'b1, 1'b0, 8'h3a);
      t_master(1'b0, 1'b1, 8'h00);
      t_slave(1'b0);
      t_slave(1'b1);
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
endmodule
